// ### iid_pkg.sv
/*
 * Shared constants for the interrupt instruction decode block.
 * Assumes a 10-bit instruction word and a 4-bit accumulator.
 */
package iid_pkg;
	localparam int IID_IW = 10;
	localparam int IID_DW = 4;
	localparam logic [9:0] IID_OP_IRQ_DISABLE = 10'h004;
	localparam logic [9:0] IID_OP_IRQ_ENABLE = 10'h005;
	localparam logic [9:0] IID_OP_EXT_FLAG_SKIP = 10'h038;
	localparam logic [9:0] IID_OP_PIN_LEVEL_SKIP = 10'h03a;
	localparam logic [9:0] IID_OP_READ_CTRL_ONE = 10'h054;
	localparam logic [9:0] IID_OP_WRITE_CTRL_ONE = 10'h03f;
	localparam logic [9:0] IID_OP_READ_CTRL_TWO = 10'h055;
	localparam logic [9:0] IID_OP_WRITE_CTRL_TWO = 10'h03e;
	localparam logic [9:0] IID_OP_READ_CTRL_THREE = 10'h253;
	localparam logic [9:0] IID_OP_WRITE_CTRL_THREE = 10'h217;
	localparam int IID_INERT_SELECT_BIT = 0;
	localparam int IID_PIN_POLARITY_BIT = 2;
	localparam logic [3:0] IID_CTRL_RST = 4'h0;
	localparam logic IID_IRQ_EN_RST = 1'b0;
	typedef enum {
		IID_NONE, IID_DIS, IID_EN, IID_FSKIP, IID_PSKIP,
		IID_RD1, IID_WR1, IID_RD2, IID_WR2, IID_RD3, IID_WR3
	} iid_op_t;
endpackage : iid_pkg

// ### iid_decode.sv
/*
 * Pure opcode decoder: maps an instruction word to an operation.
 * Assumes the word is stable while valid is high.
 */
`timescale 1ns/1ps
module iid_decode import iid_pkg::*; (
	input wire logic [IID_IW-1:0] instr,
	output iid_op_t op
);
	always_comb begin
		unique case (instr)
			IID_OP_IRQ_DISABLE: op = IID_DIS;
			IID_OP_IRQ_ENABLE: op = IID_EN;
			IID_OP_EXT_FLAG_SKIP: op = IID_FSKIP;
			IID_OP_PIN_LEVEL_SKIP: op = IID_PSKIP;
			IID_OP_READ_CTRL_ONE: op = IID_RD1;
			IID_OP_WRITE_CTRL_ONE: op = IID_WR1;
			IID_OP_READ_CTRL_TWO: op = IID_RD2;
			IID_OP_WRITE_CTRL_TWO: op = IID_WR2;
			IID_OP_READ_CTRL_THREE: op = IID_RD3;
			IID_OP_WRITE_CTRL_THREE: op = IID_WR3;
			default: op = IID_NONE;
		endcase
	end
endmodule : iid_decode

// ### iid_core.sv
/*
 * Executes the interrupt instruction group, one instruction per cycle.
 * Assumes the core presents one instruction word per valid cycle and
 * honours skip_req by dropping the next instruction it issues.
 * The core loads acc_out into the accumulator while acc_we is high.
 */
//
// Contract
// - Decode from 10-bit word, bits 9..0
// - Opcode 004 clears interrupt enable
// - Opcode 005 sets interrupt enable
// - Flag skip: skip and clear if set
// - Inert bit set: flag skip is nop
// - Inert bit is ctrl one bit 0
// - Pin skip on level per polarity
// - Polarity bit is ctrl three bit 2
// - 054 reads, 03F writes ctrl one
// - 055 reads, 03E writes ctrl two
// - 253 reads ctrl three
// - 217 writes ctrl three
`timescale 1ns/1ps
module iid_core import iid_pkg::*; #(
	parameter int DW = IID_DW
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [IID_IW-1:0] instr,
	input wire logic [DW-1:0] acc_in,
	input wire logic ext_request_set,
	input wire logic ext_irq_pin,
	output logic irq_enable,
	output logic ext_request_flag,
	output logic skip_req,
	output logic acc_we,
	output logic [DW-1:0] acc_out,
	output logic [DW-1:0] first_irq_ctrl_reg,
	output logic [DW-1:0] second_irq_ctrl_reg,
	output logic [DW-1:0] third_irq_ctrl_reg
);
	// ****************************************
	// State and internal nets
	// ****************************************
	iid_op_t op;
	iid_op_t op_v;
	logic skipping_ff;
	logic irq_en_ff;
	logic ext_flag_ff;
	logic [DW-1:0] ctrl1_ff;
	logic [DW-1:0] ctrl2_ff;
	logic [DW-1:0] ctrl3_ff;
	logic skip_ff;
	logic acc_we_ff;
	logic [DW-1:0] acc_ff;
	logic inert_select_bit;
	logic pin_polarity_bit;
	logic flag_skip;
	logic pin_skip;
	logic skip_taken;

	// ****************************************
	// Operation classes
	// ****************************************
	// Read ops all share the accumulator return path
	function automatic logic iid_is_read(input iid_op_t o);
		return (o == IID_RD1) || (o == IID_RD2) || (o == IID_RD3);
	endfunction : iid_is_read

	// Register picked by a read op; callers guard the other ops
	function automatic logic [DW-1:0] iid_read_sel(
		input iid_op_t o,
		input logic [DW-1:0] c1,
		input logic [DW-1:0] c2,
		input logic [DW-1:0] c3
	);
		unique case (o)
			IID_RD1: return c1;
			IID_RD2: return c2;
			IID_RD3: return c3;
			default: return '0;
		endcase
	endfunction : iid_read_sel

	// ****************************************
	// Decode
	// ****************************************
	// Unknown words decode to no operation
	iid_decode i_iid_decode (
		.instr(instr),
		.op(op)
	);

	// Skipped word is consumed but has no effect
	always_comb begin
		op_v = (instr_valid && !skipping_ff) ? op : IID_NONE;
	end

	// ****************************************
	// Skip conditions
	// ****************************************
	assign inert_select_bit = ctrl1_ff[IID_INERT_SELECT_BIT];
	assign pin_polarity_bit = ctrl3_ff[IID_PIN_POLARITY_BIT];
	// Inert bit makes the flag test a plain no-operation
	assign flag_skip = (op_v == IID_FSKIP) && !inert_select_bit
		&& ext_flag_ff;
	assign pin_skip = (op_v == IID_PSKIP)
		&& (ext_irq_pin == pin_polarity_bit);
	assign skip_taken = flag_skip || pin_skip;

	// ****************************************
	// Skip sequencing
	// ****************************************
	// Pending skip waits for the next valid word, idle cycles included
	always_ff @(posedge clock) begin
		if (rst) begin
			skipping_ff <= 1'b0;
		end else if (instr_valid) begin
			skipping_ff <= !skipping_ff && skip_taken;
		end
	end

	// Tells the core to drop its next word
	always_ff @(posedge clock) begin
		if (rst) begin
			skip_ff <= 1'b0;
		end else begin
			skip_ff <= skip_taken;
		end
	end

	// ****************************************
	// Interrupt enable
	// ****************************************
	// New level counts from the next instruction on
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_en_ff <= IID_IRQ_EN_RST;
		end else if (op_v == IID_DIS) begin
			irq_en_ff <= 1'b0;
		end else if (op_v == IID_EN) begin
			irq_en_ff <= 1'b1;
		end
	end

	// ****************************************
	// External request flag
	// ****************************************
	// A new request in the clearing cycle wins, so none is lost
	always_ff @(posedge clock) begin
		if (rst) begin
			ext_flag_ff <= 1'b0;
		end else if (ext_request_set) begin
			ext_flag_ff <= 1'b1;
		end else if (flag_skip) begin
			ext_flag_ff <= 1'b0;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	// All four bits load at once; no field is masked
	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl1_ff <= IID_CTRL_RST;
		end else if (op_v == IID_WR1) begin
			ctrl1_ff <= acc_in;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl2_ff <= IID_CTRL_RST;
		end else if (op_v == IID_WR2) begin
			ctrl2_ff <= acc_in;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl3_ff <= IID_CTRL_RST;
		end else if (op_v == IID_WR3) begin
			ctrl3_ff <= acc_in;
		end
	end

	// ****************************************
	// Accumulator return path
	// ****************************************
	// One-cycle load pulse for the core
	always_ff @(posedge clock) begin
		if (rst) begin
			acc_we_ff <= 1'b0;
		end else begin
			acc_we_ff <= iid_is_read(op_v);
		end
	end

	// Read data holds until the next read
	always_ff @(posedge clock) begin
		if (rst) begin
			acc_ff <= '0;
		end else if (iid_is_read(op_v)) begin
			acc_ff <= iid_read_sel(op_v, ctrl1_ff, ctrl2_ff,
				ctrl3_ff);
		end
	end

	// ****************************************
	// Status outputs
	// ****************************************
	// No carry output at all: this group never touches carry
	assign irq_enable = irq_en_ff;
	assign ext_request_flag = ext_flag_ff;
	assign skip_req = skip_ff;
	assign acc_we = acc_we_ff;
	assign acc_out = acc_ff;
	assign first_irq_ctrl_reg = ctrl1_ff;
	assign second_irq_ctrl_reg = ctrl2_ff;
	assign third_irq_ctrl_reg = ctrl3_ff;
endmodule : iid_core

// ### iid_core_asserts.sv
/* Port checker for iid_core.
   Assumes it is bound to every iid_core instance. */
`timescale 1ns/1ps
module iid_core_chk import iid_pkg::*; #(
	parameter int DW = IID_DW
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [IID_IW-1:0] instr,
	input wire logic [DW-1:0] acc_in,
	input wire logic ext_request_set,
	input wire logic ext_irq_pin,
	input wire logic irq_enable,
	input wire logic ext_request_flag,
	input wire logic skip_req,
	input wire logic acc_we,
	input wire logic [DW-1:0] acc_out,
	input wire logic [DW-1:0] first_irq_ctrl_reg,
	input wire logic [DW-1:0] second_irq_ctrl_reg,
	input wire logic [DW-1:0] third_irq_ctrl_reg
);
	// ****
	// Properties
	// ****
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Skip owed to the next valid word, idle cycles included
	logic pend_hold_ff;
	wire pend = skip_req || pend_hold_ff;
	always_ff @(posedge clock) begin
		if (rst) begin
			pend_hold_ff <= 1'b0;
		end else begin
			pend_hold_ff <= pend && !instr_valid;
		end
	end
	// Instruction taken this edge
	wire t = instr_valid && !pend;
	property p_dis; t && instr == IID_OP_IRQ_DISABLE |=> !irq_enable;
	endproperty a_dis: assert property (p_dis) else $error("dis");
	property p_en; t && instr == IID_OP_IRQ_ENABLE |=> irq_enable;
	endproperty a_en: assert property (p_en) else $error("en");
	property p_fs; t && instr == IID_OP_EXT_FLAG_SKIP && ext_request_flag
		&& !first_irq_ctrl_reg[0] && !ext_request_set
		|=> skip_req && !ext_request_flag;
	endproperty a_fs: assert property (p_fs) else $error("fskip");
	property p_in; t && instr == IID_OP_EXT_FLAG_SKIP && !ext_request_set
		&& first_irq_ctrl_reg[0] |=> !skip_req && $stable(ext_request_flag);
	endproperty a_in: assert property (p_in) else $error("inert");
	property p_ps; t && instr == IID_OP_PIN_LEVEL_SKIP
		|=> skip_req == $past(ext_irq_pin == third_irq_ctrl_reg[2]);
	endproperty a_ps: assert property (p_ps) else $error("pskip");
	property p_rd; t && instr == IID_OP_READ_CTRL_TWO
		|=> acc_we && acc_out == $past(second_irq_ctrl_reg);
	endproperty a_rd: assert property (p_rd) else $error("rd");
	property p_wr; t && instr == IID_OP_WRITE_CTRL_THREE
		|=> third_irq_ctrl_reg == $past(acc_in);
	endproperty a_wr: assert property (p_wr) else $error("wr");
	property p_sk; pend && instr_valid |=> !skip_req && !acc_we;
	endproperty a_sk: assert property (p_sk) else $error("drop");
	c_drop: cover property (skip_req && instr_valid);
	c_read: cover property (acc_we && acc_out != 4'h0);
	c_en: cover property (irq_enable);
	c_idle_drop: cover property (pend_hold_ff && instr_valid);
endmodule : iid_core_chk

bind iid_core iid_core_chk #(.DW(DW)) i_iid_core_chk (
	.clock(clock),
	.rst(rst),
	.instr_valid(instr_valid),
	.instr(instr),
	.acc_in(acc_in),
	.ext_request_set(ext_request_set),
	.ext_irq_pin(ext_irq_pin),
	.irq_enable(irq_enable),
	.ext_request_flag(ext_request_flag),
	.skip_req(skip_req),
	.acc_we(acc_we),
	.acc_out(acc_out),
	.first_irq_ctrl_reg(first_irq_ctrl_reg),
	.second_irq_ctrl_reg(second_irq_ctrl_reg),
	.third_irq_ctrl_reg(third_irq_ctrl_reg)
);

// ### tb.sv
/* Self-checking bench for iid_core.
   Assumes the checker file is compiled alongside. */
`timescale 1ns/1ps
module tb import iid_pkg::*;;
	// ****
	// Stimulus and checks
	// ****
	logic clock = 0, rst = 1, instr_valid = 0;
	logic ext_request_set = 0, ext_irq_pin = 0;
	logic [9:0] instr = 10'h000;
	logic [3:0] acc_in = 4'h0, acc_out;
	logic [3:0] first_irq_ctrl_reg, second_irq_ctrl_reg, third_irq_ctrl_reg;
	logic irq_enable, ext_request_flag, skip_req, acc_we;
	int err_count = 0, n_tests = 0;
	logic [9:0] w[3] = '{IID_OP_WRITE_CTRL_ONE, IID_OP_WRITE_CTRL_TWO,
		IID_OP_WRITE_CTRL_THREE};
	logic [9:0] r[3] = '{IID_OP_READ_CTRL_ONE, IID_OP_READ_CTRL_TWO,
		IID_OP_READ_CTRL_THREE};
	logic [3:0] d[3] = '{4'ha, 4'h5, 4'h4};
	iid_core i_iid_core (
		.clock(clock),
		.rst(rst),
		.instr_valid(instr_valid),
		.instr(instr),
		.acc_in(acc_in),
		.ext_request_set(ext_request_set),
		.ext_irq_pin(ext_irq_pin),
		.irq_enable(irq_enable),
		.ext_request_flag(ext_request_flag),
		.skip_req(skip_req),
		.acc_we(acc_we),
		.acc_out(acc_out),
		.first_irq_ctrl_reg(first_irq_ctrl_reg),
		.second_irq_ctrl_reg(second_irq_ctrl_reg),
		.third_irq_ctrl_reg(third_irq_ctrl_reg)
	);
	always #50 clock = ~clock;
	task ex(input logic [9:0] op, input logic [3:0] a);
		instr = op;
		acc_in = a;
		instr_valid = 1;
		@(posedge clock);
		#1;
	endtask : ex
	task chk(input string n, input logic [11:0] s, input logic [11:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task chk_rst;
		chk("rst", {irq_enable, ext_request_flag, skip_req, acc_we,
			acc_out}, 0);
		chk("rst_regs", {first_irq_ctrl_reg, second_irq_ctrl_reg,
			third_irq_ctrl_reg}, 0);
	endtask : chk_rst
	task report_and_stop;
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (12) @(posedge clock);
		#1 rst = 0;
		chk_rst;
		ex(IID_OP_IRQ_ENABLE, 0);
		chk("en", irq_enable, 1);
		ex(IID_OP_IRQ_DISABLE, 0);
		chk("dis", irq_enable, 0);
		for (int k = 0; k < 3; k++)
			ex(w[k], d[k]);
		chk("wr", {first_irq_ctrl_reg, second_irq_ctrl_reg,
			third_irq_ctrl_reg}, 12'ha54);
		for (int k = 0; k < 3; k++) begin
			ex(r[k], 4'h0);
			chk("rd", {acc_we, acc_out}, {1'b1, d[k]});
		end
		ext_request_set = 1;
		ex(IID_OP_IRQ_DISABLE, 0);
		chk("rd_hold", {acc_we, acc_out}, 5'h04);
		ext_request_set = 0;
		ex(IID_OP_EXT_FLAG_SKIP, 0);
		chk("fskip", {skip_req, ext_request_flag}, 2'b10);
		ex(IID_OP_IRQ_ENABLE, 0);
		chk("drop", {irq_enable, skip_req}, 0);
		ex(IID_OP_EXT_FLAG_SKIP, 0);
		chk("noflag", skip_req, 0);
		ex(IID_OP_WRITE_CTRL_ONE, 4'h1);
		ext_request_set = 1;
		ex(IID_OP_IRQ_DISABLE, 0);
		ext_request_set = 0;
		ex(IID_OP_EXT_FLAG_SKIP, 0);
		chk("inert", {skip_req, ext_request_flag}, 2'b01);
		for (int p = 0; p < 4; p++) begin
			ex(IID_OP_WRITE_CTRL_THREE, p[1] ? 4'h4 : 4'hb);
			ext_irq_pin = p[0];
			ex(IID_OP_PIN_LEVEL_SKIP, 0);
			chk("pskip", skip_req, p[0] == p[1]);
			ex(IID_OP_IRQ_DISABLE, 0);
		end
		// Pending skip must survive an idle cycle
		ex(IID_OP_PIN_LEVEL_SKIP, 0);
		chk("pskip_hi", skip_req, 1);
		instr_valid = 0;
		@(posedge clock);
		#1;
		chk("pulse", skip_req, 0);
		ex(IID_OP_IRQ_ENABLE, 0);
		chk("idle_drop", irq_enable, 0);
		// A skipped skip never skips
		ex(IID_OP_PIN_LEVEL_SKIP, 0);
		ex(IID_OP_PIN_LEVEL_SKIP, 0);
		chk("skip_skip", skip_req, 0);
		ex(IID_OP_IRQ_ENABLE, 0);
		chk("en_after", irq_enable, 1);
		// Reset in mid-run clears everything again
		instr_valid = 0;
		rst = 1;
		@(posedge clock);
		#1;
		rst = 0;
		chk_rst;
		report_and_stop;
	end
endmodule : tb
